// [hls_pkg.sv]
// Package: constants, register map and types of the lead/lag supervisor
package hls_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned TICK_SEC      = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ * TICK_SEC;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned SEC_PER_HOUR  = 3600;

  // ---------------------------------------------------------------------
  // Register word indices (byte address = index * 4)
  // ---------------------------------------------------------------------
  localparam logic [3:0] REG_ECON_CFG   = 4'h0;
  localparam logic [3:0] REG_ECON_CFG2  = 4'h1;
  localparam logic [3:0] REG_ALARM_CFG  = 4'h2;
  localparam logic [3:0] REG_ALARM_CFG2 = 4'h3;
  localparam logic [3:0] REG_SYS_CFG    = 4'h4;
  localparam logic [3:0] REG_BYPASS     = 4'h5;
  localparam logic [3:0] REG_REMOTE     = 4'h6;
  localparam logic [3:0] REG_STATUS     = 4'h7;
  localparam logic [3:0] REG_CTRL_TEMP  = 4'h8;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] DEF_UPPER      = 8'h41; // 65
  localparam logic [7:0] DEF_LOWER      = 8'h41; // 65
  localparam logic [7:0] DEF_FLOAT      = 8'h05;
  localparam logic [9:0] DEF_DWELL      = 10'h03c; // 60 s
  localparam logic [7:0] DEF_HUM_CUT    = 8'h00;
  localparam logic [7:0] DEF_HI2        = 8'h5a; // 90
  localparam logic [7:0] DEF_HI1        = 8'h55; // 85
  localparam logic [7:0] DEF_LOW        = 8'h32; // 50
  localparam logic [7:0] DEF_HUM_ALM    = 8'h00;
  localparam logic [8:0] DEF_RESID      = 9'h01e; // 30 s
  localparam logic [8:0] DEF_LEAD_HRS   = 9'h0a8; // 168 h
  localparam logic [8:0] MAX_RESID      = 9'h12c; // 300 s
  localparam logic [9:0] MIN_DWELL      = 10'h03c;
  localparam logic [9:0] MAX_DWELL      = 10'h384;
  localparam logic [7:0] MAX_FLOAT      = 8'h0a;

  // Sensor validity window, signed degrees F
  localparam logic signed [9:0] SENS_MIN = -10'sd25;
  localparam logic signed [9:0] SENS_MAX = 10'sd150;

  // ---------------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    IN_DISABLE, IN_NC, IN_NO
  } hls_input_mode_e;

  typedef enum logic [2:0] {
    BYP_HEAT, BYP_BYPASS_COOL_TWO_STAGES, BYP_BYPASS_COOL_STAGE_ONE, BYP_ECON, BYP_OFF
  } hls_bypass_e;

  typedef enum logic [1:0] {
    SRC_ZONE1, SRC_ZONE2, SRC_AVG, SRC_HIGH
  } hls_source_e;

  typedef enum logic [1:0] {
    FAN_AUTO, FAN_LEAD, FAN_BOTH
  } hls_fan_e;

  typedef enum logic [1:0] {
    ZN_NONE, ZN_ABOVE, ZN_MID, ZN_BELOW
  } hls_zone_e;

endpackage : hls_pkg

// [hls_supervisor.sv]
// Top: lead/lag supervisor for two HVAC units with Avalon-MM registers
// ---------------------------------------------------------------------
//
// Decided for this implementation: the Avalon-MM register port and the address map.
module hls_supervisor
  import hls_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Avalon-MM slave
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Sensors (signed degrees F, humidity percent)
  input  wire logic signed [9:0] zone1_temp,
  input  wire logic signed [9:0] zone2_temp,
  input  wire logic signed [9:0] outdoor_air_temp,
  input  wire logic [7:0]        humidity,
  // Contact inputs, raw pin level, one per unit where paired
  input  wire logic [1:0]        lockout_pin,
  input  wire logic [1:0]        ctrl_volt_ok,
  input  wire logic              smoke_pin,
  input  wire logic              hydrogen_pin,
  input  wire logic              genrun_pin,
  input  wire logic              lead_button,
  // Staging calls and economizer feedback from the staging logic, plus the comm fault flag
  input  wire logic              call_heat,
  input  wire logic              call_bypass_cool_stage_one,
  input  wire logic              call_bypass_cool_two_stages,
  input  wire logic              call_econ,
  input  wire logic              econ_success,
  input  wire logic              econ_failure,
  input  wire logic              econ_lag_need,
  input  wire logic              comm_fault,
  // Unit relay outputs, bit 0 unit A, bit 1 unit B
  output logic [1:0]             fan_out,
  output logic [1:0]             heat_out,
  output logic [1:0]             bypass_cool_stage_one_out,
  output logic [1:0]             bypass_cool_two_stages_out,
  output logic [1:0]             econ_out,
  // Alarm and status outputs
  output logic                   alarm_hi2,
  output logic                   alarm_hi1,
  output logic                   alarm_low,
  output logic                   sensor_error,
  output logic                   lead_unit,
  output logic                   restart_req
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [26:0]     tick_cnt;
    logic            tick;
    logic [7:0]      upper;
    logic [7:0]      lower;
    logic [7:0]      upper_base;
    logic [7:0]      float_lim;
    logic [9:0]      dwell;
    logic [7:0]      hum_cut;
    logic [7:0]      hi2_sp;
    logic [7:0]      hi1_sp;
    logic [7:0]      low_sp;
    logic [7:0]      hum_alm_sp;
    hls_input_mode_e lock_mode;
    hls_input_mode_e smoke_mode;
    hls_input_mode_e h2_mode;
    hls_input_mode_e gen_mode;
    hls_source_e     src;
    hls_fan_e        fan_mode;
    logic            standby;
    logic [8:0]      resid;
    logic [8:0]      lead_hrs;
    hls_bypass_e     byp_mode;
    logic [15:0]     byp_sec;
    logic            remote_valid;
    logic signed [9:0] remote_temp;
    logic            remote_switch;
    logic            restart;
    hls_zone_e       zone;
    hls_zone_e       cand;
    logic [9:0]      dwell_cnt;
    logic [8:0]      resid_cnt;
    logic [21:0]     lead_sec;
    logic            lead;
    logic            econ_ok;
    logic            hum_alarm;
    logic signed [9:0] ctrl_temp;
    logic            sens_err;
    logic [1:0]      fan;
    logic [1:0]      heat;
    logic [1:0]      c1;
    logic [1:0]      c2;
    logic [1:0]      econ;
    logic            a_hi2;
    logic            a_hi1;
    logic            a_low;
    logic [31:0]     rdata;
    logic            ack;
  } hls_state_s;

  hls_state_s q, d;

  // Pin synchronisers, two stages each
  logic [7:0] sync1_q, sync2_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= {lead_button, genrun_pin, hydrogen_pin, smoke_pin,
                  ctrl_volt_ok, lockout_pin};
      sync2_q <= sync1_q;
    end
  end

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic contact(hls_input_mode_e m, logic pin);
    case (m)
      IN_NC:   contact = !pin; // Alarm when the loop opens
      IN_NO:   contact = pin;
      default: contact = 1'b0; // Disabled never alarms
    endcase
  endfunction : contact

  function automatic logic valid_t(logic signed [9:0] t);
    valid_t = (t >= SENS_MIN) && (t <= SENS_MAX);
  endfunction : valid_t

  logic [1:0] lock_alm;
  logic       smoke_alm, h2_alm, gen_alm, btn_rise;
  logic       btn_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) btn_q <= 1'b0;
    else btn_q <= sync2_q[7];
  end
  assign lock_alm[0] = contact(q.lock_mode, sync2_q[0]);
  assign lock_alm[1] = contact(q.lock_mode, sync2_q[1]);
  assign smoke_alm   = contact(q.smoke_mode, sync2_q[4]);
  assign h2_alm      = contact(q.h2_mode, sync2_q[5]);
  assign gen_alm     = contact(q.gen_mode, sync2_q[6]);
  assign btn_rise    = sync2_q[7] && !btn_q;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    logic        wr, rd, lead_fail, lag_fail, sw_req, calls, auto_on;
    logic        v1, v2, any_call;
    logic signed [10:0] sum;
    logic signed [9:0]  tsens;
    logic [1:0]  ld, lg;
    hls_zone_e   now_zone;
    wr = 1'b0; rd = 1'b0; lead_fail = 1'b0; lag_fail = 1'b0;
    sw_req = 1'b0; calls = 1'b0; auto_on = 1'b0; v1 = 1'b0; v2 = 1'b0;
    any_call = 1'b0; sum = '0; tsens = '0; ld = '0; lg = '0;
    now_zone = ZN_NONE;
    d = q;

    // One-second tick
    d.tick = 1'b0;
    if (q.tick_cnt == 27'(TICK_DIV - 1)) begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 27'h1;
    end

    // Bus: one wait cycle; a write lands as waitrequest is seen low
    wr = avs_write && q.ack;
    rd = avs_read && !q.ack;
    d.ack = (avs_read || avs_write) && !q.ack;
    d.remote_switch = 1'b0;
    d.restart = 1'b0;
    if (wr) begin
      if (avs_address[5:2] == REG_ECON_CFG) begin
        d.upper = avs_writedata[7:0];
        d.upper_base = avs_writedata[7:0];
        d.lower = avs_writedata[15:8];
        d.float_lim = (avs_writedata[23:16] > MAX_FLOAT) ? MAX_FLOAT
                      : avs_writedata[23:16];
        d.hum_cut = avs_writedata[31:24];
      end else if (avs_address[5:2] == REG_ECON_CFG2) begin
        d.dwell = (avs_writedata[9:0] < MIN_DWELL) ? MIN_DWELL
                : (avs_writedata[9:0] > MAX_DWELL) ? MAX_DWELL
                : avs_writedata[9:0];
      end else if (avs_address[5:2] == REG_ALARM_CFG) begin
        d.hi2_sp = avs_writedata[7:0];
        d.hi1_sp = avs_writedata[15:8];
        d.low_sp = avs_writedata[23:16];
        d.hum_alm_sp = avs_writedata[31:24];
      end else if (avs_address[5:2] == REG_ALARM_CFG2) begin
        d.lock_mode  = hls_input_mode_e'(avs_writedata[1:0]);
        d.smoke_mode = hls_input_mode_e'(avs_writedata[3:2]);
        d.h2_mode    = hls_input_mode_e'(avs_writedata[5:4]);
        d.gen_mode   = hls_input_mode_e'(avs_writedata[7:6]);
      end else if (avs_address[5:2] == REG_SYS_CFG) begin
        d.src = hls_source_e'(avs_writedata[1:0]);
        d.fan_mode = hls_fan_e'(avs_writedata[3:2]);
        d.standby = avs_writedata[4];
        d.resid = (avs_writedata[16:8] > MAX_RESID) ? MAX_RESID
                  : avs_writedata[16:8];
        d.lead_hrs = avs_writedata[25:17];
        d.restart = avs_writedata[31]; // Store and reboot
      end else if (avs_address[5:2] == REG_BYPASS) begin
        d.byp_mode = hls_bypass_e'(avs_writedata[2:0]);
        d.byp_sec = 16'(avs_writedata[15:8] * SEC_PER_MIN);
      end else if (avs_address[5:2] == REG_REMOTE) begin
        d.remote_temp = avs_writedata[9:0];
        d.remote_valid = 1'b1;
        d.remote_switch = avs_writedata[16];
      end
    end
    d.rdata = 32'h0;
    if (rd) begin
      if (avs_address[5:2] == REG_ECON_CFG) begin
        d.rdata = {q.hum_cut, q.float_lim, q.lower, q.upper};
      end else if (avs_address[5:2] == REG_ECON_CFG2) begin
        d.rdata = {22'h0, q.dwell};
      end else if (avs_address[5:2] == REG_ALARM_CFG) begin
        d.rdata = {q.hum_alm_sp, q.low_sp, q.hi1_sp, q.hi2_sp};
      end else if (avs_address[5:2] == REG_ALARM_CFG2) begin
        d.rdata = {24'h0, q.gen_mode, q.h2_mode, q.smoke_mode, q.lock_mode};
      end else if (avs_address[5:2] == REG_SYS_CFG) begin
        d.rdata = {6'h0, q.lead_hrs, q.resid, 3'h0, q.standby,
                   q.fan_mode, q.src};
      end else if (avs_address[5:2] == REG_BYPASS) begin
        d.rdata = {16'h0, q.byp_sec[15:8], 5'h0, q.byp_mode};
      end else if (avs_address[5:2] == REG_STATUS) begin
        d.rdata = {20'h0, gen_alm, h2_alm, smoke_alm, q.hum_alarm,
                   q.sens_err, q.a_low, q.a_hi1, q.a_hi2,
                   q.econ_ok, 2'(q.zone), q.lead};
      end else if (avs_address[5:2] == REG_CTRL_TEMP) begin
        d.rdata = {22'h0, q.ctrl_temp};
      end
    end
    if (comm_fault) d.remote_valid = 1'b0; // Revert on fault

    // Controlling temperature
    v1 = valid_t(zone1_temp);
    v2 = valid_t(zone2_temp);
    sum = 11'(zone1_temp) + 11'(zone2_temp);
    d.sens_err = 1'b0;
    case (q.src)
      SRC_ZONE1: begin
        tsens = zone1_temp;
        d.sens_err = !v1;
      end
      SRC_ZONE2: begin
        tsens = zone2_temp;
        d.sens_err = !v2;
      end
      default: begin
        if (v1 && v2) begin
          tsens = (q.src == SRC_AVG) ? sum[10:1]
                : (zone1_temp > zone2_temp) ? zone1_temp : zone2_temp;
        end else if (v1) begin
          tsens = zone1_temp;
        end else begin
          tsens = zone2_temp;
        end
        d.sens_err = !v1 && !v2;
      end
    endcase
    d.ctrl_temp = q.remote_valid ? q.remote_temp : tsens;
    if (q.remote_valid) d.sens_err = 1'b0;

    // Alarms
    d.a_hi2 = q.ctrl_temp > $signed({2'b00, q.hi2_sp});
    d.a_hi1 = q.ctrl_temp > $signed({2'b00, q.hi1_sp});
    d.a_low = q.ctrl_temp < $signed({2'b00, q.low_sp});
    d.hum_alarm = (q.hum_alm_sp != 8'h00) && (humidity > q.hum_alm_sp);

    // Outdoor band with dwell filter
    now_zone = (outdoor_air_temp > $signed({2'b00, q.upper})) ? ZN_ABOVE
             : (outdoor_air_temp < $signed({2'b00, q.lower})) ? ZN_BELOW
             : ZN_MID;
    if (now_zone != q.cand) begin
      d.cand = now_zone;
      d.dwell_cnt = '0;
    end else if (q.tick && q.zone != q.cand) begin
      if (q.dwell_cnt + 10'h1 >= q.dwell) begin
        d.zone = q.cand;
      end else begin
        d.dwell_cnt = q.dwell_cnt + 10'h1;
      end
    end
    d.econ_ok = (q.zone == ZN_MID || q.zone == ZN_BELOW) && !gen_alm
              && !smoke_alm
              && !(q.hum_cut != 8'h00 && humidity > q.hum_cut);

    // Threshold float within limit, both move together
    if (q.tick && econ_success &&
        q.upper < q.upper_base + q.float_lim) begin
      d.upper = q.upper + 8'h1;
      d.lower = q.lower + 8'h1;
    end else if (q.tick && econ_failure &&
                 q.upper + q.float_lim > q.upper_base) begin
      d.upper = q.upper - 8'h1;
      d.lower = q.lower - 8'h1;
    end

    // Lead switching
    lead_fail = lock_alm[q.lead] || !sync2_q[2 + q.lead];
    lag_fail = lock_alm[!q.lead] || !sync2_q[2 + !q.lead];
    if (q.tick) d.lead_sec = q.lead_sec + 22'h1;
    sw_req = btn_rise || q.remote_switch || lead_fail ||
             (d.a_hi2 && !q.a_hi2) || (q.lead_hrs != 9'h0 &&
              q.lead_sec >= 22'(q.lead_hrs * SEC_PER_HOUR));
    if (sw_req && !lag_fail) begin
      d.lead = !q.lead;
      d.lead_sec = '0;
    end

    // Normal outputs with lead/lag or standby
    ld = q.lead ? 2'b10 : 2'b01;
    lg = q.standby ? 2'b00 : ~ld;
    calls = call_heat || call_bypass_cool_stage_one || call_bypass_cool_two_stages ||
            (call_econ && q.econ_ok);
    any_call = calls && !q.sens_err && !smoke_alm;
    d.heat = (call_heat && any_call) ? (ld | lg) : 2'b00;
    d.c1 = (call_bypass_cool_stage_one && any_call) ? (ld | lg) : 2'b00;
    d.c2 = (call_bypass_cool_two_stages && any_call) ? (ld | lg) : 2'b00;
    d.econ = 2'b00;
    if (call_econ && q.econ_ok && any_call) begin
      d.econ = ld;
      if (q.zone == ZN_MID || econ_lag_need) d.econ = ld | lg;
    end

    // Fan modes and residual delay
    if (any_call) begin
      d.resid_cnt = q.resid;
    end else if (q.tick && q.resid_cnt != 9'h0) begin
      d.resid_cnt = q.resid_cnt - 9'h1;
    end
    auto_on = any_call || q.resid_cnt != 9'h0;
    case (q.fan_mode)
      FAN_LEAD: d.fan = ld | (auto_on ? lg : 2'b00);
      FAN_BOTH: d.fan = 2'b11;
      default:  d.fan = auto_on ? (ld | lg) : 2'b00;
    endcase
    if (q.sens_err) d.fan = 2'b11;
    if (smoke_alm) d.fan = 2'b00;

    // Bypass override
    if (q.byp_sec != 16'h0) begin
      if (q.tick) d.byp_sec = q.byp_sec - 16'h1;
      d.fan = (q.byp_mode == BYP_OFF) ? 2'b00 : 2'b11;
      d.heat = (q.byp_mode == BYP_HEAT) ? 2'b11 : 2'b00;
      d.c1 = (q.byp_mode == BYP_BYPASS_COOL_STAGE_ONE || q.byp_mode == BYP_BYPASS_COOL_TWO_STAGES)
             ? 2'b11 : 2'b00;
      d.c2 = (q.byp_mode == BYP_BYPASS_COOL_TWO_STAGES) ? 2'b11 : 2'b00;
      d.econ = (q.byp_mode == BYP_ECON) ? 2'b11 : 2'b00;
    end
  end

  // Register the state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.upper <= DEF_UPPER;
      q.upper_base <= DEF_UPPER;
      q.lower <= DEF_LOWER;
      q.float_lim <= DEF_FLOAT;
      q.dwell <= DEF_DWELL;
      q.hum_cut <= DEF_HUM_CUT;
      q.hi2_sp <= DEF_HI2;
      q.hi1_sp <= DEF_HI1;
      q.low_sp <= DEF_LOW;
      q.hum_alm_sp <= DEF_HUM_ALM;
      q.resid <= DEF_RESID;
      q.lead_hrs <= DEF_LEAD_HRS;
      q.byp_mode <= BYP_OFF;
      q.lock_mode <= IN_NC;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = !q.ack;
  assign fan_out   = q.fan;
  assign heat_out  = q.heat;
  assign bypass_cool_stage_one_out = q.c1;
  assign bypass_cool_two_stages_out = q.c2;
  assign econ_out  = q.econ;
  assign alarm_hi2 = q.a_hi2;
  assign alarm_hi1 = q.a_hi1;
  assign alarm_low = q.a_low;
  assign sensor_error = q.sens_err;
  assign lead_unit = q.lead;
  assign restart_req = q.restart;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  chk_sens_fans: assert property (@(posedge clk)
    disable iff (!reset_n) q.sens_err && q.byp_sec == 16'h0 && !smoke_alm
    |=> fan_out == 2'b11 && heat_out == 2'b00)
    else $error("sensor error outputs");
  chk_bypass_off: assert property (@(posedge clk)
    disable iff (!reset_n) q.byp_sec != 16'h0 && q.byp_mode == BYP_OFF
    |=> fan_out == 2'b00) else $error("bypass off fan");
  chk_lead_block: assert property (@(posedge clk)
    disable iff (!reset_n) lock_alm[!q.lead] || !sync2_q[2 + !q.lead]
    |=> $stable(q.lead)) else $error("lead switched to failed unit");
  chk_standby_only: assert property (@(posedge clk)
    disable iff (!reset_n) q.standby && q.byp_sec == 16'h0 |=>
    ((heat_out | bypass_cool_stage_one_out) & ~($past(q.lead) ? 2'b10 : 2'b01)) == 2'b00)
    else $error("standby ran");
  chk_hum_alarm: assert property (@(posedge clk)
    disable iff (!reset_n) q.hum_alm_sp == 8'h00 |=> !q.hum_alarm)
    else $error("humidity alarm while disabled");
  chk_econ_high: assert property (@(posedge clk)
    disable iff (!reset_n) q.zone == ZN_ABOVE && $past(q.zone) == ZN_ABOVE
    && q.byp_sec == 16'h0 |=> econ_out == 2'b00)
    else $error("econ above upper");
  chk_tick_gap: assert property (@(posedge clk)
    disable iff (!reset_n) q.tick |=> !q.tick) else $error("tick too long");
  chk_float_lim: assert property (@(posedge clk)
    disable iff (!reset_n) q.upper <= q.upper_base + q.float_lim)
    else $error("float beyond limit");

endmodule : hls_supervisor

// [hls_unit_model.sv]
// Partner model: the two HVAC units' contact and control voltage lines
module hls_unit_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Failure commands from the bench
  input  wire logic [1:0] volt_fail,
  input  wire logic [1:0] lock_fail,
  // Unit contacts
  output logic      [1:0] lockout_pin,
  output logic      [1:0] ctrl_volt_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lockout loops are closed while healthy and open on a commanded lockout
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lockout_pin <= 2'h3;
    end else begin
      lockout_pin <= ~lock_fail;
    end
  end
  // Control voltage drops on command, marking the unit failed
  assign ctrl_volt_ok = ~volt_fail;
endmodule : hls_unit_model

// [testbench.sv]
// Testbench: self-checking bench of the lead/lag supervisor
module testbench;
  import hls_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, smoke_pin;
  logic hydrogen_pin, genrun_pin, lead_button, call_heat, comm_fault;
  logic call_bypass_cool_stage_one, call_bypass_cool_two_stages, call_econ, restart_req;
  logic [7:0] humidity;
  logic alarm_hi2, alarm_hi1, alarm_low, sensor_error, lead_unit;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic signed [9:0] zone1_temp;
  logic [1:0] lockout_pin, ctrl_volt_ok, volt_fail, lock_fail;
  logic [1:0] fan_out, heat_out, bypass_cool_stage_one_out, bypass_cool_two_stages_out, econ_out;
  int errors, checks, cyc, restarts;
  logic [13:0] rows [5] = '{14'h046_0, 14'h056_4, 14'h05f_c,
                            14'h028_2, 14'h0c8_d};
  logic [9:0] byp [5] = '{10'h3c0, 10'h33c, 10'h330, 10'h303, 10'h000};
  // ---------------------------------------------------------------------
  // Design and partner
  // ---------------------------------------------------------------------
  hls_supervisor #(.TICK_DIV(10)) u_dut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .zone1_temp(zone1_temp), .zone2_temp(zone1_temp),
    .outdoor_air_temp(10'sd70), .humidity(humidity),
    .lockout_pin(lockout_pin), .ctrl_volt_ok(ctrl_volt_ok),
    .smoke_pin(smoke_pin), .hydrogen_pin(hydrogen_pin),
    .genrun_pin(genrun_pin), .lead_button(lead_button),
    .call_heat(call_heat), .call_bypass_cool_stage_one(call_bypass_cool_stage_one),
    .call_bypass_cool_two_stages(call_bypass_cool_two_stages), .call_econ(call_econ),
    .econ_success(1'b0), .econ_failure(1'b0),
    .econ_lag_need(1'b0), .comm_fault(comm_fault), .fan_out(fan_out),
    .heat_out(heat_out), .bypass_cool_stage_one_out(bypass_cool_stage_one_out), .bypass_cool_two_stages_out(bypass_cool_two_stages_out),
    .econ_out(econ_out), .alarm_hi2(alarm_hi2), .alarm_hi1(alarm_hi1),
    .alarm_low(alarm_low), .sensor_error(sensor_error),
    .lead_unit(lead_unit), .restart_req(restart_req));
  hls_unit_model u_units (.clk(clk), .reset_n(reset_n),
    .volt_fail(volt_fail), .lock_fail(lock_fail), .lockout_pin(lockout_pin),
    .ctrl_volt_ok(ctrl_volt_ok));
  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  // Compare one result and count it
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One Avalon-MM cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] i,
                     input logic [31:0] d);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  // Press the lead button long enough to pass the synchroniser
  task automatic press();
    lead_button <= 1'b1;
    repeat (8) @(posedge clk);
    lead_button <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : press
  // Print the counts and the verdict, then stop
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // ---------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Count restart pulses; more than one per request is an error
  always @(posedge clk) begin
    if (restart_req === 1'b1) restarts++;
  end
  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    {reset_n, avs_read, avs_write, smoke_pin, hydrogen_pin} = '0;
    {genrun_pin, lead_button, call_heat, comm_fault, volt_fail} = '0;
    {call_bypass_cool_stage_one, call_bypass_cool_two_stages, call_econ, humidity, lock_fail} = '0;
    avs_address = '0;
    avs_writedata = '0;
    zone1_temp = 10'sd70;
    repeat (8) @(posedge clk);
    chk("fan_rst", 2'h0, fan_out);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, REG_ECON_CFG, 32'h0);
    chk("econ_def", 32'h00054141, rd);
    bus(1'b0, REG_ALARM_CFG, 32'h0);
    chk("alarm_def", 32'h0032555a, rd);
    bus(1'b1, REG_ALARM_CFG2, 32'h0);
    lock_fail <= 2'h1;
    repeat (20) @(posedge clk);
    chk("lead_dis", 1'b0, lead_unit);
    lock_fail <= 2'h0;
    repeat (4) @(posedge clk);
    press();
    chk("lead_btn", 1'b1, lead_unit);
    volt_fail <= 2'h1;
    press();
    chk("lead_blk", 1'b1, lead_unit);
    volt_fail <= 2'h0;
    repeat (4) @(posedge clk);
    bus(1'b1, REG_REMOTE, 32'h00010000);
    repeat (4) @(posedge clk);
    chk("lead_rem", 1'b0, lead_unit);
    comm_fault <= 1'b1;
    @(posedge clk);
    comm_fault <= 1'b0;
    $display("test lead done");
    // Alarm rows: zone temperature beside hi2, hi1, low, sensor error
    foreach (rows[k]) begin
      zone1_temp <= rows[k][13:4];
      repeat (8) @(posedge clk);
      chk("alarms", rows[k][3:0],
          {alarm_hi2, alarm_hi1, alarm_low, sensor_error});
    end
    call_heat <= 1'b1;
    repeat (8) @(posedge clk);
    chk("err_fan", 2'h3, fan_out);
    chk("err_heat", 2'h0, heat_out);
    call_heat <= 1'b0;
    zone1_temp <= 10'sd70;
    bus(1'b1, REG_REMOTE, 32'h0000005f);
    repeat (8) @(posedge clk);
    chk("remote_t", 1'b1, alarm_hi1);
    comm_fault <= 1'b1;
    repeat (8) @(posedge clk);
    chk("comm_flt", 1'b0, alarm_hi1);
    $display("test alarms done");
    // Bypass rows: mode beside expected fan, heat, bypass_cool_stage_one, bypass_cool_two_stages, econ
    foreach (byp[k]) begin
      bus(1'b1, REG_BYPASS, {16'h0, 8'h01, 5'h0, 3'(k)});
      repeat (6) @(posedge clk);
      chk("bypass", byp[k], {fan_out, heat_out, bypass_cool_stage_one_out, bypass_cool_two_stages_out,
          econ_out});
    end
    bus(1'b1, REG_BYPASS, 32'h0);
    call_heat <= 1'b1;
    repeat (12) @(posedge clk);
    chk("byp_cancel", 1'b1, heat_out !== 2'h0);
    call_heat <= 1'b0;
    repeat (280) @(posedge clk);
    chk("resid_on", 1'b1, fan_out !== 2'h0);
    repeat (50) @(posedge clk);
    chk("resid_off", 2'h0, fan_out);
    $display("test bypass and fan done");
    // Economizer with humidity cutoff, then cooling in both control methods
    bus(1'b1, REG_ECON_CFG, 32'h3205414b);
    repeat (640) @(posedge clk);
    call_econ <= 1'b1;
    humidity <= 8'h28;
    repeat (8) @(posedge clk);
    chk("econ_mid", 2'h3, econ_out);
    humidity <= 8'h3c;
    repeat (8) @(posedge clk);
    chk("econ_hum", 2'h0, econ_out);
    {call_econ, call_bypass_cool_stage_one, call_bypass_cool_two_stages} <= 3'b011;
    repeat (8) @(posedge clk);
    chk("cool_both", 4'hf, {bypass_cool_stage_one_out, bypass_cool_two_stages_out});
    bus(1'b1, REG_SYS_CFG, 32'h81501e10);
    repeat (8) @(posedge clk);
    chk("standby", 1'b1, $onehot(bypass_cool_stage_one_out));
    chk("restart", 1'b1, restarts);
    $display("test econ and cooling done");
    tally_and_finish();
  end
endmodule : testbench
